// [logic/start_seq_pkg.sv]
package start_seq_pkg;
   // clock and tick timing
   localparam int CLK_PERIOD_NS  = 100;
   localparam int TICK_PERIOD_NS = 1000000000;
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

   // widths
   localparam int SPEED_W   = 16;
   localparam int TIME_W    = 12;
   localparam int FUEL_W    = 11;
   localparam int CUST_DI_N = 11;   // inputs 5-8 and 18-24
   localparam int PIN_N     = 5;

   // step times in seconds: defaults and ranges
   localparam logic [11:0] CRANK_ALARM_S    = 12'd30;
   localparam logic [11:0] PURGE_DEF_S      = 12'd20;
   localparam logic [11:0] PURGE_MIN_S      = 12'd5;
   localparam logic [11:0] PURGE_MAX_S      = 12'd3000;
   localparam logic [11:0] LITE_GAS_DEF_S   = 12'd10;
   localparam logic [11:0] LITE_LIQ_DEF_S   = 12'd15;
   localparam logic [11:0] LITE_MIN_S       = 12'd2;
   localparam logic [11:0] LITE_MAX_S       = 12'd30;
   localparam logic [11:0] WARMUP_DEF_S     = 12'd20;
   localparam logic [11:0] STEP_MIN_S       = 12'd5;
   localparam logic [11:0] STEP_MAX_S       = 12'd600;
   localparam logic [11:0] ACCEL_PT_DEF_S   = 12'd60;

   // speeds, rates and the exhaust temperature limit
   localparam logic [15:0] MIN_CRANK_DEF_RPM = 16'd1000;
   localparam logic [15:0] PT_RATED_DEF_RPM  = 16'd3600;
   localparam logic [15:0] PT_RATED_MIN_RPM  = 16'd100;
   localparam logic [15:0] PT_RATED_MAX_RPM  = 16'd20000;
   localparam logic [15:0] GG_RATE_DEF_RPM_S = 16'd20;
   localparam logic [15:0] GG_RATE_FAST_RPM_S = 16'd50;
   localparam logic [15:0] EGT_LIMIT_DEGF    = 16'd400;

   // fuel start ramp in tenths of a percent
   localparam logic [10:0] FUEL_STEP_PER_S = 11'd3;
   localparam logic [10:0] FUEL_FULL       = 11'd1000;

   typedef enum logic [8:0] {
      ST_STOPPED  = 9'h001,
      ST_CRANK    = 9'h002,
      ST_PURGE    = 9'h004,
      ST_LITEOFF  = 9'h008,
      ST_ACCEL_GG = 9'h010,
      ST_WARMUP   = 9'h020,
      ST_ACCEL_PT = 9'h040,
      ST_REACHED  = 9'h080,
      ST_COMPLETE = 9'h100
   } seq_state_t;
endpackage : start_seq_pkg

// [logic/pin_filter.sv]
`timescale 1ns/10ps
// three-stage filter for pins from outside the clock domain
module pin_filter #(
   parameter int N = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic [N-1:0] pin_in,
   output logic      [N-1:0] level_q
);
   logic [N-1:0] s1_q, s2_q, s3_q;
   logic [N-1:0] level_d;

   // a change counts only once stages two and three agree
   always_comb begin
      for (int i = 0; i < N; i++) begin
         level_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : level_q[i];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         level_q <= '0;
      end else begin
         s1_q    <= pin_in;
         s2_q    <= s1_q;   // s1 feeds nothing else
         s3_q    <= s2_q;
         level_q <= level_d;
      end
   end
endmodule : pin_filter

// [logic/step_timer.sv]
`timescale 1ns/10ps
// seconds elapsed in the current step, saturating
module step_timer #(
   parameter int W = 12
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic         restart,
   input  wire logic         tick,
   output logic      [W-1:0] elapsed_q
);
   logic [W-1:0] elapsed_d;

   // restart wins over a tick in the same cycle
   always_comb begin
      elapsed_d = elapsed_q;
      if (restart) begin
         elapsed_d = '0;
      end else if (tick && elapsed_q != {W{1'b1}}) begin
         elapsed_d = elapsed_q + W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         elapsed_q <= '0;
      end else begin
         elapsed_q <= elapsed_d;
      end
   end
endmodule : step_timer

// [logic/turbine_start_sequencer.sv]
`timescale 1ns/10ps
module turbine_start_sequencer #(
   parameter int TICK_CYCLES = start_seq_pkg::TICK_CYCLES
) (
   input  wire logic                     sys_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     start_cmd,
   input  wire logic                     shutdown_pin,
   input  wire logic                     calibrate_pin,
   input  wire logic                     manual_crank_pin,
   input  wire logic                     valves_closed_pin,
   input  wire logic                     flame_pin,
   input  wire logic [10:0]              discrete_input_perm,
   input  wire logic [10:0]              discrete_input_enable,
   input  wire logic [15:0]              exhaust_gas_temperature,
   input  wire logic                     metering_at_min,
   input  wire logic [15:0]              gas_generator_shaft_rpm,
   input  wire logic [15:0]              power_turbine_shaft_rpm,
   input  wire logic                     power_turbine_in_control,
   input  wire logic [15:0]              min_crank_rpm,
   input  wire logic [15:0]              starter_cutout_rpm,
   input  wire logic [15:0]              gas_generator_idle_rpm,
   input  wire logic [15:0]              gas_generator_min_ref,
   input  wire logic [15:0]              gas_generator_max_ref,
   input  wire logic [15:0]              power_turbine_idle_ref,
   input  wire logic [15:0]              power_turbine_rated_cfg,
   input  wire logic [11:0]              purge_time_s,
   input  wire logic [11:0]              liteoff_gas_time_s,
   input  wire logic [11:0]              liteoff_liquid_time_s,
   input  wire logic [11:0]              accel_idle_time_s,
   input  wire logic [11:0]              warmup_time_s,
   input  wire logic [11:0]              accel_pt_time_s,
   input  wire logic                     fast_rate_sel,
   input  wire logic                     fuel_is_liquid,
   input  wire logic                     end_at_idle,
   output logic                          starter_relay_q,
   output logic                          ignitor_q,
   output logic                          gas_valve_open_q,
   output logic                          liquid_valve_open_q,
   output logic [10:0]                   fuel_ramp_q,
   output logic [15:0]                   gas_generator_ref_q,
   output logic [15:0]                   power_turbine_ref_q,
   output logic                          pt_rated_pulse_q,
   output logic                          shutdown_cmd_q,
   output logic                          crank_alarm_q,
   output logic                          fail_liteoff_q,
   output logic                          gg_fail_accel_q,
   output logic                          pt_fail_accel_q,
   output logic                          sequence_complete_q,
   output start_seq_pkg::seq_state_t     state_q
);
   localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp16

   logic [4:0]   pins_q;
   logic [11:0]  elapsed_s;
   logic [TW-1:0] tick_cnt_q, tick_cnt_d;
   logic         tick;
   start_seq_pkg::seq_state_t state_d;
   logic         starter_relay_d, ignitor_d, gas_valve_open_d, liquid_valve_open_d;
   logic [10:0]  fuel_ramp_d;
   logic [15:0]  gas_generator_ref_d, power_turbine_ref_d;
   logic         pt_rated_pulse_d, shutdown_cmd_d, sequence_complete_d;
   logic         crank_alarm_d, fail_liteoff_d, gg_fail_accel_d, pt_fail_accel_d;
   logic         shutdown_active, calibrate_mode, manual_crank, valves_closed, flame_seen;
   logic         permissive_ok, fault;
   logic [11:0]  purge_lim, liteoff_lim, accel_lim, warmup_lim, pt_lim;
   logic [15:0]  pt_rated, gg_rate;
   logic [16:0]  gg_sum, pt_sum;
   logic [11:0]  fuel_sum;

   // pin inputs cross in through the three-stage filter
   pin_filter #(.N(start_seq_pkg::PIN_N)) u_pins (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin_in  ({shutdown_pin, calibrate_pin, manual_crank_pin, valves_closed_pin, flame_pin}),
      .level_q (pins_q)
   );
   assign {shutdown_active, calibrate_mode, manual_crank, valves_closed, flame_seen} = pins_q;

   // one step timer, restarted on every step change
   step_timer #(.W(start_seq_pkg::TIME_W)) u_timer (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .restart   (state_d != state_q),
      .tick      (tick),
      .elapsed_q (elapsed_s)
   );

   // one second tick from the system clock
   always_comb begin
      tick       = (tick_cnt_q == TW'(TICK_CYCLES - 1));
      tick_cnt_d = tick ? '0 : tick_cnt_q + TW'(1);
   end

   // configured limits pulled into their legal ranges, except accel_lim, which is taken from accel_idle_time_s unclamped
   always_comb begin
      purge_lim   = 12'(clamp16({4'h0, purge_time_s}, {4'h0, start_seq_pkg::PURGE_MIN_S},
                            {4'h0, start_seq_pkg::PURGE_MAX_S}));
      liteoff_lim = 12'(clamp16({4'h0, fuel_is_liquid ? liteoff_liquid_time_s : liteoff_gas_time_s},
                            {4'h0, start_seq_pkg::LITE_MIN_S}, {4'h0, start_seq_pkg::LITE_MAX_S}));
      accel_lim   = accel_idle_time_s;
      warmup_lim  = 12'(clamp16({4'h0, warmup_time_s}, {4'h0, start_seq_pkg::STEP_MIN_S},
                            {4'h0, start_seq_pkg::STEP_MAX_S}));
      pt_lim      = 12'(clamp16({4'h0, accel_pt_time_s}, {4'h0, start_seq_pkg::STEP_MIN_S},
                            {4'h0, start_seq_pkg::STEP_MAX_S}));
      pt_rated    = clamp16(power_turbine_rated_cfg, start_seq_pkg::PT_RATED_MIN_RPM,
                            start_seq_pkg::PT_RATED_MAX_RPM);
      gg_rate     = fast_rate_sel ? start_seq_pkg::GG_RATE_FAST_RPM_S
                                  : start_seq_pkg::GG_RATE_DEF_RPM_S;
   end

   // permissives: all true together, customer inputs masked by enable
   assign permissive_ok = !shutdown_active && !calibrate_mode && !manual_crank
                       && (exhaust_gas_temperature < start_seq_pkg::EGT_LIMIT_DEGF)
                       && valves_closed && metering_at_min
                       && (gas_generator_ref_q == gas_generator_min_ref)
                       && (power_turbine_ref_q == power_turbine_idle_ref)
                       && (&(discrete_input_perm | ~discrete_input_enable));

   // sequence next state and outputs
   always_comb begin
      state_d             = state_q;
      starter_relay_d     = starter_relay_q;
      ignitor_d           = ignitor_q;
      gas_valve_open_d    = gas_valve_open_q;
      liquid_valve_open_d = liquid_valve_open_q;
      fuel_ramp_d         = fuel_ramp_q;
      gas_generator_ref_d = gas_generator_ref_q;
      power_turbine_ref_d = power_turbine_ref_q;
      pt_rated_pulse_d    = 1'b0;
      shutdown_cmd_d      = 1'b0;
      sequence_complete_d = sequence_complete_q;
      crank_alarm_d       = crank_alarm_q;
      fail_liteoff_d      = fail_liteoff_q;
      gg_fail_accel_d     = gg_fail_accel_q;
      pt_fail_accel_d     = pt_fail_accel_q;
      fault               = 1'b0;
      gg_sum   = {1'b0, gas_generator_ref_q} + {1'b0, gg_rate};
      pt_sum   = {1'b0, power_turbine_ref_q} + {1'b0, start_seq_pkg::GG_RATE_DEF_RPM_S};
      fuel_sum = {1'b0, fuel_ramp_q} + {1'b0, start_seq_pkg::FUEL_STEP_PER_S};
      unique case (state_q)
         start_seq_pkg::ST_STOPPED: begin
            gas_generator_ref_d = gas_generator_min_ref;
            power_turbine_ref_d = power_turbine_idle_ref;
            fuel_ramp_d         = '0;
            if (start_cmd && permissive_ok) begin
               state_d             = start_seq_pkg::ST_CRANK;
               starter_relay_d     = 1'b1;
               sequence_complete_d = 1'b0;
               crank_alarm_d       = 1'b0;   // flags kept from last attempt until now
               fail_liteoff_d      = 1'b0;
               gg_fail_accel_d     = 1'b0;
               pt_fail_accel_d     = 1'b0;
            end
         end
         start_seq_pkg::ST_CRANK: begin
            if (gas_generator_shaft_rpm > min_crank_rpm) begin
               state_d = start_seq_pkg::ST_PURGE;
            end else if (elapsed_s >= start_seq_pkg::CRANK_ALARM_S) begin
               crank_alarm_d = 1'b1;
            end
         end
         start_seq_pkg::ST_PURGE: begin
            if (elapsed_s >= purge_lim) begin
               state_d             = start_seq_pkg::ST_LITEOFF;
               ignitor_d           = 1'b1;
               gas_valve_open_d    = !fuel_is_liquid;
               liquid_valve_open_d = fuel_is_liquid;
            end
         end
         start_seq_pkg::ST_LITEOFF: begin
            if (flame_seen) begin
               state_d   = start_seq_pkg::ST_ACCEL_GG;
               ignitor_d = 1'b0;
            end else if (elapsed_s >= liteoff_lim) begin
               fault          = 1'b1;
               fail_liteoff_d = 1'b1;
            end
         end
         start_seq_pkg::ST_ACCEL_GG: begin
            if (tick) begin
               fuel_ramp_d = (fuel_sum > {1'b0, start_seq_pkg::FUEL_FULL}) ? start_seq_pkg::FUEL_FULL
                                                                           : fuel_sum[10:0];
            end
            if (gas_generator_shaft_rpm > starter_cutout_rpm) begin
               starter_relay_d = 1'b0;
            end
            if (gas_generator_shaft_rpm >= gas_generator_idle_rpm) begin
               state_d     = start_seq_pkg::ST_WARMUP;
               fuel_ramp_d = start_seq_pkg::FUEL_FULL;   // speed loop takes over
            end else if (elapsed_s >= accel_lim) begin
               fault           = 1'b1;
               gg_fail_accel_d = 1'b1;
            end
         end
         start_seq_pkg::ST_WARMUP: begin
            starter_relay_d = 1'b0;
            if (elapsed_s >= warmup_lim) begin
               if (end_at_idle) begin
                  state_d             = start_seq_pkg::ST_COMPLETE;
                  sequence_complete_d = 1'b1;
               end else begin
                  state_d          = start_seq_pkg::ST_ACCEL_PT;
                  pt_rated_pulse_d = 1'b1;
               end
            end
         end
         start_seq_pkg::ST_ACCEL_PT: begin
            if (tick) begin
               gas_generator_ref_d = (gg_sum > {1'b0, gas_generator_max_ref}) ? gas_generator_max_ref
                                                                              : gg_sum[15:0];
               power_turbine_ref_d = (pt_sum > {1'b0, pt_rated}) ? pt_rated : pt_sum[15:0];
            end
            if (power_turbine_in_control && power_turbine_shaft_rpm >= pt_rated) begin
               state_d = start_seq_pkg::ST_REACHED;
            end else if (elapsed_s >= pt_lim) begin
               fault           = 1'b1;
               pt_fail_accel_d = 1'b1;
            end
         end
         start_seq_pkg::ST_REACHED: begin
            gas_generator_ref_d = gas_generator_max_ref;
            power_turbine_ref_d = pt_rated;
            sequence_complete_d = 1'b1;
            state_d             = start_seq_pkg::ST_COMPLETE;
         end
         start_seq_pkg::ST_COMPLETE: begin
         end
         default: begin
            state_d = start_seq_pkg::ST_STOPPED;   // illegal code recovers to stopped
         end
      endcase
      // shutdown from the pin or a step fault, outside stopped, forces stopped and turns off relay, ignitor, valves and fuel ramp
      if ((shutdown_active || fault) && state_q != start_seq_pkg::ST_STOPPED) begin
         state_d             = start_seq_pkg::ST_STOPPED;
         starter_relay_d     = 1'b0;
         ignitor_d           = 1'b0;
         gas_valve_open_d    = 1'b0;
         liquid_valve_open_d = 1'b0;
         fuel_ramp_d         = '0;
         sequence_complete_d = 1'b0;
         pt_rated_pulse_d    = 1'b0;
         shutdown_cmd_d      = fault;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tick_cnt_q          <= '0;
         state_q             <= start_seq_pkg::ST_STOPPED;
         starter_relay_q     <= 1'b0;
         ignitor_q           <= 1'b0;
         gas_valve_open_q    <= 1'b0;
         liquid_valve_open_q <= 1'b0;
         fuel_ramp_q         <= '0;
         gas_generator_ref_q <= '0;
         power_turbine_ref_q <= '0;
         pt_rated_pulse_q    <= 1'b0;
         shutdown_cmd_q      <= 1'b0;
         sequence_complete_q <= 1'b0;
         crank_alarm_q       <= 1'b0;
         fail_liteoff_q      <= 1'b0;
         gg_fail_accel_q     <= 1'b0;
         pt_fail_accel_q     <= 1'b0;
      end else begin
         tick_cnt_q          <= tick_cnt_d;
         state_q             <= state_d;
         starter_relay_q     <= starter_relay_d;
         ignitor_q           <= ignitor_d;
         gas_valve_open_q    <= gas_valve_open_d;
         liquid_valve_open_q <= liquid_valve_open_d;
         fuel_ramp_q         <= fuel_ramp_d;
         gas_generator_ref_q <= gas_generator_ref_d;
         power_turbine_ref_q <= power_turbine_ref_d;
         pt_rated_pulse_q    <= pt_rated_pulse_d;
         shutdown_cmd_q      <= shutdown_cmd_d;
         sequence_complete_q <= sequence_complete_d;
         crank_alarm_q       <= crank_alarm_d;
         fail_liteoff_q      <= fail_liteoff_d;
         gg_fail_accel_q     <= gg_fail_accel_d;
         pt_fail_accel_q     <= pt_fail_accel_d;
      end
   end

   // checks on the sequence
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_start_needs_perm: assert property (state_q == start_seq_pkg::ST_STOPPED && !(start_cmd && permissive_ok)
      |=> state_q == start_seq_pkg::ST_STOPPED) else $error("left stopped without permissives");
   a_crank_starter_on: assert property ($rose(state_q == start_seq_pkg::ST_CRANK) |-> starter_relay_q)
      else $error("starter off on crank entry");
   a_crank_alarm_time: assert property ($rose(crank_alarm_q) |-> $past(state_q) == start_seq_pkg::ST_CRANK
      && $past(elapsed_s) >= 12'd30) else $error("crank alarm too early");
   a_liteoff_outputs: assert property (state_q == start_seq_pkg::ST_LITEOFF |-> ignitor_q
      && (gas_valve_open_q ^ liquid_valve_open_q)) else $error("lite-off outputs wrong");
   a_liteoff_fail: assert property ($rose(fail_liteoff_q) |-> shutdown_cmd_q
      && state_q == start_seq_pkg::ST_STOPPED) else $error("failed lite-off without shutdown");
   a_cutout_starter: assert property (state_q == start_seq_pkg::ST_ACCEL_GG
      && gas_generator_shaft_rpm > starter_cutout_rpm && !shutdown_active |=> !starter_relay_q)
      else $error("starter held past cutout");
   a_pulse_single: assert property (pt_rated_pulse_q |=> !pt_rated_pulse_q
      && state_q != start_seq_pkg::ST_WARMUP) else $error("rated pulse not single");
   a_gg_ref_max: assert property ($rose(sequence_complete_q) && !end_at_idle
      |-> gas_generator_ref_q == gas_generator_max_ref) else $error("reference not at maximum");
   a_shutdown_stops: assert property (shutdown_active && state_q != start_seq_pkg::ST_STOPPED
      |=> state_q == start_seq_pkg::ST_STOPPED && !starter_relay_q && !ignitor_q && !gas_valve_open_q
      && !liquid_valve_open_q) else $error("shutdown left outputs on");
   a_fuel_ramp_step: assert property (state_q == start_seq_pkg::ST_ACCEL_GG && state_d == state_q
      && !fault && !shutdown_active && tick && fuel_ramp_q < 11'd990 |=> fuel_ramp_q == $past(fuel_ramp_q) + 11'd3)
      else $error("fuel ramp step wrong");

   c_reach_purge: cover property (state_q == start_seq_pkg::ST_PURGE);
   c_liteoff_fail: cover property ($rose(fail_liteoff_q));
   c_complete_rated: cover property ($rose(sequence_complete_q) && !end_at_idle);
   c_complete_idle: cover property ($rose(sequence_complete_q) && end_at_idle);
endmodule : turbine_start_sequencer

// [sim/turbine_plant.sv]
`timescale 1ns/10ps
// shaft and flame model: starter cranks, lit fuel accelerates, pt shaft follows its reference
module turbine_plant (
   input  wire logic        sys_clk, sys_rst, starter_relay_q, ignitor_q, flame_ok,
   input  wire logic        gas_valve_open_q, liquid_valve_open_q,
   input  wire logic [15:0] power_turbine_ref_q, power_turbine_rated_cfg,
   output logic      [15:0] gas_generator_shaft_rpm, power_turbine_shaft_rpm,
   output logic             flame_pin, valves_closed_pin, metering_at_min, power_turbine_in_control
);
   logic [15:0] gg_d, pt_d;
   logic        lit_d, fuel_on;
   // valve and metering feedback straight from the commands
   assign fuel_on = gas_valve_open_q | liquid_valve_open_q;
   assign valves_closed_pin = ~fuel_on;
   assign metering_at_min = ~fuel_on;
   assign power_turbine_in_control = power_turbine_shaft_rpm >= power_turbine_rated_cfg;
   // flame lives only while fuel flows; starter alone stalls near 2000 rpm
   always_comb begin
      lit_d = fuel_on & (flame_pin | (ignitor_q & flame_ok));
      gg_d  = gas_generator_shaft_rpm;
      pt_d  = power_turbine_ref_q;
      if (lit_d && gg_d < 16'h1f40) gg_d = gg_d + 16'h0014;
      else if (starter_relay_q && gg_d < 16'h07d0) gg_d = gg_d + 16'h0014;
      else if (!lit_d && !starter_relay_q && gg_d != 16'h0000) gg_d = gg_d - 16'h0001;
      if (power_turbine_shaft_rpm < power_turbine_ref_q) pt_d = power_turbine_shaft_rpm + 16'h0032;
   end
   // plain state registers
   always_ff @(posedge sys_clk) begin
      gas_generator_shaft_rpm <= sys_rst ? 16'h0000 : gg_d;
      power_turbine_shaft_rpm <= sys_rst ? 16'h0000 : pt_d;
      flame_pin               <= sys_rst ? 1'b0 : lit_d;
   end
endmodule : turbine_plant

// [sim/turbine_start_sequencer_test.sv]
`timescale 1ns/10ps
module turbine_start_sequencer_test;
   logic sys_clk = 1'b0, sys_rst = 1'b1, start_cmd = 1'b0, shutdown_pin = 1'b0, calibrate_pin = 1'b0;
   logic manual_crank_pin = 1'b0, fast_rate_sel = 1'b0, fuel_is_liquid = 1'b0, end_at_idle = 1'b0, flame_ok = 1'b1;
   logic valves_closed_pin, flame_pin, metering_at_min, power_turbine_in_control, pulse_seen = 1'b0;
   logic starter_relay_q, ignitor_q, gas_valve_open_q, liquid_valve_open_q, pt_rated_pulse_q, shutdown_cmd_q;
   logic crank_alarm_q, fail_liteoff_q, gg_fail_accel_q, pt_fail_accel_q, sequence_complete_q;
   logic [10:0] discrete_input_perm = 11'h7ff, discrete_input_enable = 11'h000, fuel_ramp_q;
   logic [15:0] exhaust_gas_temperature = 16'h0064, min_crank_rpm = 16'h03e8, starter_cutout_rpm = 16'h0bb8;
   logic [15:0] gas_generator_idle_rpm = 16'h1388, gas_generator_min_ref = 16'h03e8, gas_generator_max_ref = 16'h2328;
   logic [15:0] power_turbine_idle_ref = 16'h0dac, power_turbine_rated_cfg = 16'h0e10, gas_generator_ref_q;
   logic [15:0] gas_generator_shaft_rpm, power_turbine_shaft_rpm, power_turbine_ref_q;
   logic [11:0] purge_time_s = 12'h001, liteoff_gas_time_s = 12'h01e, liteoff_liquid_time_s = 12'h002;
   logic [11:0] accel_idle_time_s = 12'h01e, warmup_time_s = 12'h005, accel_pt_time_s = 12'h014;
   start_seq_pkg::seq_state_t state_q, last_q = start_seq_pkg::ST_STOPPED, exp_q[$];
   int          errors = 0, tests_run = 0, dwell = 0, k, shut_cnt = 0;
   // one second is ten cycles here, so every step fits in a short run
   turbine_start_sequencer #(.TICK_CYCLES(10)) uut (.*);
   turbine_plant plant (.*);
   initial forever #50 sys_clk = ~sys_clk;
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   task automatic wait_state(start_seq_pkg::seq_state_t s);
      for (int n = 0; n < 2000 && state_q !== s; n++) @(posedge sys_clk);
      if (state_q !== s) begin
         check("state wait", 16'(state_q), 16'(s));
         wrap_up();
      end
   endtask : wait_state
   // each state change must match the oldest note; purge dwell shows the clamp to 5 s
   always @(posedge sys_clk) begin
      if (!sys_rst && state_q !== last_q) begin
         if (exp_q.size() == 0) check("unexpected state", 16'(state_q), 16'h0000);
         else check("state order", 16'(state_q), 16'(exp_q.pop_front()));
         if (last_q === start_seq_pkg::ST_PURGE)
            check("purge dwell", 16'(dwell > 40 && dwell < 52), 16'h0001);
         dwell = 0;
      end else dwell++;
      if (pt_rated_pulse_q === 1'b1) pulse_seen = 1'b1;
      if (shutdown_cmd_q === 1'b1) shut_cnt++;   // one-cycle pulse, counted once
      last_q <= state_q;
   end
   initial begin
      void'($urandom(78));
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (10) @(posedge sys_clk);
      // refused starts: exhaust at the limit, then one enabled customer input false
      for (k = 0; k < 2; k++) begin
         exhaust_gas_temperature <= k ? 16'h0064 : 16'h0190;
         discrete_input_enable   <= k ? (11'($urandom) | 11'h001) : 11'h000;
         discrete_input_perm     <= k ? 11'h7fe : 11'h7ff;
         start_cmd               <= 1'b1;
         repeat (20) @(posedge sys_clk);
         check("refused", 16'(state_q), 16'(start_seq_pkg::ST_STOPPED));
      end
      $display("refused start test done");
      exp_q = '{start_seq_pkg::ST_CRANK, start_seq_pkg::ST_PURGE, start_seq_pkg::ST_LITEOFF,
                start_seq_pkg::ST_ACCEL_GG, start_seq_pkg::ST_WARMUP, start_seq_pkg::ST_ACCEL_PT,
                start_seq_pkg::ST_REACHED, start_seq_pkg::ST_COMPLETE};
      fast_rate_sel       <= 1'($urandom);
      discrete_input_perm <= 11'h7ff;
      wait_state(start_seq_pkg::ST_COMPLETE);
      @(posedge sys_clk);
      check("gg ref max", gas_generator_ref_q, 16'h2328);
      check("complete", 16'(sequence_complete_q), 16'h0001);
      check("rated pulse", 16'(pulse_seen), 16'h0001);
      check("starter off", 16'(starter_relay_q), 16'h0000);
      check("fuel ramp full", 16'(fuel_ramp_q), 16'(start_seq_pkg::FUEL_FULL));
      check("pt ref rated", power_turbine_ref_q, power_turbine_rated_cfg);
      check("flags", 16'({crank_alarm_q, fail_liteoff_q, gg_fail_accel_q, pt_fail_accel_q}), 16'h0000);
      $display("full start test done");
      // shutdown, then a liquid lite-off that never lights
      exp_q = '{start_seq_pkg::ST_STOPPED, start_seq_pkg::ST_CRANK, start_seq_pkg::ST_PURGE,
                start_seq_pkg::ST_LITEOFF, start_seq_pkg::ST_STOPPED};
      start_cmd    <= 1'b0;
      shutdown_pin <= 1'b1;
      wait_state(start_seq_pkg::ST_STOPPED);
      check("outputs off", 16'({starter_relay_q, ignitor_q, gas_valve_open_q}), 16'h0000);
      shutdown_pin   <= 1'b0;
      flame_ok       <= 1'b0;
      fuel_is_liquid <= 1'b1;
      start_cmd      <= 1'b1;
      wait_state(start_seq_pkg::ST_LITEOFF);
      @(posedge sys_clk);
      check("liquid lite", 16'({ignitor_q, liquid_valve_open_q, gas_valve_open_q}), 16'h0006);
      wait_state(start_seq_pkg::ST_STOPPED);
      @(posedge sys_clk);
      check("lite fail", 16'({fail_liteoff_q, starter_relay_q}), 16'h0002);
      $display("failed lite-off test done");
      // start_cmd stays high: the restart cranks toward a speed it can never pass
      exp_q = '{start_seq_pkg::ST_CRANK, start_seq_pkg::ST_STOPPED};
      min_crank_rpm <= 16'hffff;
      wait_state(start_seq_pkg::ST_CRANK);
      for (k = 0; k < 320 && crank_alarm_q !== 1'b1; k++) @(posedge sys_clk);
      check("crank alarm", 16'({crank_alarm_q, starter_relay_q, k > 280}), 16'h0007);
      shutdown_pin <= 1'b1;
      wait_state(start_seq_pkg::ST_STOPPED);
      check("fault pulses", 16'(shut_cnt), 16'h0001);
      $display("crank alarm test done");
      wrap_up();
   end
endmodule : turbine_start_sequencer_test
